// *** ecsd_pkg.sv ***
`default_nettype none
package ecsd_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int ECSD_FRAME_BITS = 16;
	localparam int ECSD_CMD_LSB    = 12;
	localparam int ECSD_IDX_LSB    = 8;
	localparam logic [4:0] ECSD_CNT_LAST = 5'h0F;
	localparam logic [4:0] ECSD_CNT_MAX  = 5'h11;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [3:0] ECSD_CMD_ECHO     = 4'h0;
	localparam logic [3:0] ECSD_CMD_RD_CFG   = 4'h1;
	localparam logic [3:0] ECSD_CMD_WR_CFG   = 4'h2;
	localparam logic [3:0] ECSD_CMD_RD_STAT  = 4'h3;
	localparam logic [3:0] ECSD_CMD_WR_STAT  = 4'h4;
	localparam logic [3:0] ECSD_CMD_RD_CTRL  = 4'h5;
	localparam logic [3:0] ECSD_CMD_WR_CTRL  = 4'h6;
	localparam logic [3:0] ECSD_CMD_ECHO_RSP = 4'h7;

	// ****************************************
	// Register banks
	// ****************************************
	localparam int ECSD_CFG_COUNT  = 9;
	localparam int ECSD_CTRL_COUNT = 10;
	localparam int ECSD_STAT_COUNT = 14;

	localparam logic [7:0] ECSD_CFG_RESET [ECSD_CFG_COUNT] = '{
		8'h10, 8'h10, 8'h18, 8'h10, 8'h01, 8'h18, 8'h00, 8'h10, 8'h80};
	localparam logic [7:0] ECSD_CFG_MASK [ECSD_CFG_COUNT] = '{
		8'h9F, 8'h9F, 8'h9F, 8'hDF, 8'hFF, 8'h9B, 8'h83, 8'hD7, 8'hD7};

	localparam logic [7:0] ECSD_CTRL_RESET [ECSD_CTRL_COUNT] = '{
		8'h00, 8'h12, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] ECSD_CTRL_MASK [ECSD_CTRL_COUNT] = '{
		8'hFF, 8'hD7, 8'h7F, 8'h7F, 8'h7F,
		8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F};

	localparam logic [7:0] ECSD_STAT_RESET = 8'h00;
	localparam logic [7:0] ECSD_STAT_MASK  = 8'hFF;

	// Self test enable lives in control register 1, bit 6
	localparam int ECSD_SELF_TEST_REG = 1;
	localparam int ECSD_SELF_TEST_BIT = 6;

endpackage
`default_nettype wire

// *** ecsd_command_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Every frame is exactly 16 bits, command code in the top 4 bits and data in the low 12.
// - Every operating parameter is kept in an 8-bit register.
// - Command codes 0 to 6 decode as echo, read/write config, status and control; code 7 (echo reply) is not decoded and replies zero.
// - Writes store their own frame's data; reads answer in the next frame only.
// - A frame is acted on only when the active-low select input rises.
// - Commands are taken at any time with no extra gap or handshake.
// - An echo command returns every bit just as it was sent.
// - Three banks, configuration, control and status, of host readable and writable registers.
// - Configuration registers hold retry, load sink, inrush, combine and PWM rate fields.
// - Control registers command outputs on or off and hold PWM duty values.
// - Status registers report faults and conditions of each block to the host.
// - Every register bit takes its own default value after reset.
// - Non-existent bits read zero and ignore writes.
// - With self test enabled the host may write any status bit, otherwise only clear them.

module ecsd_command_decoder
	import ecsd_pkg::*;
(
	// Clock and reset
	input  wire logic                         i_mclk,
	input  wire logic                         i_rst_n,
	// Serial link
	input  wire logic                         i_sclk,
	input  wire logic                         i_select_n_input,
	input  wire logic                         i_mosi,
	output logic                              o_miso,
	output logic                              o_miso_oe_n,
	// Status condition inputs, one bit per status bit
	input  wire logic [ECSD_STAT_COUNT*8-1:0] i_status_set,
	// Register contents to the drivers
	output logic [ECSD_CFG_COUNT*8-1:0]       o_config_bank,
	output logic [ECSD_CTRL_COUNT*8-1:0]      o_control_bank,
	output logic [ECSD_STAT_COUNT*8-1:0]      o_status_bank,
	output logic                              o_self_test_enable,
	// Frame executed strobe
	output logic                              o_frame_exec
);

	// ****************************************
	// Link side, serial clock domain
	// ****************************************
	logic        link_clr;
	logic [4:0]  bit_cnt;
	logic [15:0] rx_shift;
	logic [15:0] tx_shift;
	logic        frame_good;
	logic        frame_tgl;
	logic        miso_q;
	logic [15:0] resp;

	// Select high holds the counter clear, so each frame starts at zero
	assign link_clr = i_select_n_input | ~i_rst_n;

	// ****************************************
	// Bit counter
	// ****************************************
	always_ff @(posedge i_sclk or posedge link_clr) begin
		if (link_clr) begin
			bit_cnt <= 5'h00;
		end else if (bit_cnt != ECSD_CNT_MAX) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// ****************************************
	// Receive shifter, first bit is the top bit
	// ****************************************
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_shift <= 16'h0000;
		end else begin
			rx_shift <= {rx_shift[14:0], i_mosi};
		end
	end

	// ****************************************
	// Frame length check
	// ****************************************
	// High only when the last edge of the frame was the sixteenth
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_good <= 1'b0;
		end else begin
			frame_good <= (bit_cnt == ECSD_CNT_LAST);
		end
	end

	// ****************************************
	// Frame toggle
	// ****************************************
	// Toggles once per frame so an empty select pulse is never executed
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_tgl <= 1'b0;
		end else if (bit_cnt == 5'h00) begin
			frame_tgl <= ~frame_tgl;
		end
	end

	// ****************************************
	// Reply shifter
	// ****************************************
	// Reply word is still here, as select stays high between frames
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_shift <= 16'h0000;
		end else if (bit_cnt == 5'h00) begin
			tx_shift <= resp;
		end
	end

	// ****************************************
	// Data out register
	// ****************************************
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= tx_shift[~bit_cnt[3:0]];
		end
	end

	// ****************************************
	// Data out pin
	// ****************************************
	// First bit shows before any clock edge, straight from the reply word
	assign o_miso      = (bit_cnt == 5'h00) ? resp[15] : miso_q;
	assign o_miso_oe_n = i_select_n_input;

	// ****************************************
	// Crossing into the main clock
	// ****************************************
	logic sel_meta;
	logic sel_sync;
	logic sel_prev;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic sel_rise;
	logic exec;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_meta <= 1'b1;
			sel_sync <= 1'b1;
			sel_prev <= 1'b1;
		end else begin
			sel_meta <= i_select_n_input;
			sel_sync <= sel_meta;
			sel_prev <= sel_sync;
		end
	end

	// ****************************************
	// Frame toggle synchroniser
	// ****************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
		end else begin
			tgl_meta <= frame_tgl;
			tgl_sync <= tgl_meta;
		end
	end

	// ****************************************
	// Select rising edge
	// ****************************************
	assign sel_rise = sel_sync & ~sel_prev;

	// ****************************************
	// Frame acceptance
	// ****************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_seen <= 1'b0;
		end else if (sel_rise) begin
			tgl_seen <= tgl_sync;
		end
	end

	// ****************************************
	// Execute strobe
	// ****************************************
	// Link word is still while select is high, so it is read directly
	assign exec = sel_rise & (tgl_sync != tgl_seen) & frame_good;

	// ****************************************
	// Executed frame flag
	// ****************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_frame_exec <= 1'b0;
		end else begin
			o_frame_exec <= exec;
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	logic [3:0] cmd;
	logic [3:0] idx;
	logic [7:0] val;
	logic       cfg_wr;
	logic       ctrl_wr;
	logic       stat_wr;

	assign cmd = rx_shift[ECSD_FRAME_BITS-1:ECSD_CMD_LSB];
	assign idx = rx_shift[ECSD_CMD_LSB-1:ECSD_IDX_LSB];
	assign val = rx_shift[ECSD_IDX_LSB-1:0];

	// ****************************************
	// Write enables
	// ****************************************
	assign cfg_wr  = exec & (cmd == ECSD_CMD_WR_CFG);
	assign ctrl_wr = exec & (cmd == ECSD_CMD_WR_CTRL);
	assign stat_wr = exec & (cmd == ECSD_CMD_WR_STAT);

	// ****************************************
	// Register banks
	// ****************************************
	logic [7:0] cfg  [ECSD_CFG_COUNT];
	logic [7:0] ctrl [ECSD_CTRL_COUNT];
	logic [7:0] stat [ECSD_STAT_COUNT];
	logic [7:0] next_stat [ECSD_STAT_COUNT];
	logic       self_test;

	// ****************************************
	// Self test flag
	// ****************************************
	assign self_test = ctrl[ECSD_SELF_TEST_REG][ECSD_SELF_TEST_BIT];
	assign o_self_test_enable = self_test;

	generate
		// ****************************************
		// Configuration bank
		// ****************************************
		for (genvar i = 0; i < ECSD_CFG_COUNT; i++) begin : g_cfg
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					cfg[i] <= ECSD_CFG_RESET[i];
				end else if (cfg_wr && idx == 4'(i)) begin
					cfg[i] <= val & ECSD_CFG_MASK[i];
				end
			end
			assign o_config_bank[i*8 +: 8] = cfg[i];
		end

		// ****************************************
		// Control bank
		// ****************************************
		for (genvar i = 0; i < ECSD_CTRL_COUNT; i++) begin : g_ctrl
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					ctrl[i] <= ECSD_CTRL_RESET[i];
				end else if (ctrl_wr && idx == 4'(i)) begin
					ctrl[i] <= val & ECSD_CTRL_MASK[i];
				end
			end
			assign o_control_bank[i*8 +: 8] = ctrl[i];
		end

		// ****************************************
		// Status bank
		// ****************************************
		for (genvar i = 0; i < ECSD_STAT_COUNT; i++) begin : g_stat
			logic       hit;
			logic [7:0] base;
			assign hit  = stat_wr & (idx == 4'(i));
			// Host writes freely in self test, else only clears
			assign base = !hit ? stat[i]
				: (self_test ? val : (stat[i] & val));
			// Condition set wins over a clear in the same cycle
			assign next_stat[i] = (base | i_status_set[i*8 +: 8])
				& ECSD_STAT_MASK;
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					stat[i] <= ECSD_STAT_RESET;
				end else begin
					stat[i] <= next_stat[i];
				end
			end
			assign o_status_bank[i*8 +: 8] = stat[i];
		end
	endgenerate

	// ****************************************
	// Read back and reply word
	// ****************************************
	logic [7:0] rd_val;

	always_comb begin
		rd_val = 8'h00;
		case (cmd)
			ECSD_CMD_RD_CFG: begin
				if (idx < 4'(ECSD_CFG_COUNT)) begin
					rd_val = cfg[idx];
				end
			end
			ECSD_CMD_RD_STAT: begin
				if (idx < 4'(ECSD_STAT_COUNT)) begin
					rd_val = stat[idx];
				end
			end
			ECSD_CMD_RD_CTRL: begin
				if (idx < 4'(ECSD_CTRL_COUNT)) begin
					rd_val = ctrl[idx];
				end
			end
			default: begin
				rd_val = 8'h00;
			end
		endcase
	end

	// ****************************************
	// Reply word
	// ****************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			resp <= 16'h0000;
		end else if (exec) begin
			case (cmd)
				ECSD_CMD_ECHO: begin
					resp <= rx_shift;
				end
				ECSD_CMD_RD_CFG, ECSD_CMD_RD_STAT, ECSD_CMD_RD_CTRL: begin
					resp <= {cmd, idx, rd_val};
				end
				ECSD_CMD_WR_CFG, ECSD_CMD_WR_STAT, ECSD_CMD_WR_CTRL: begin
					resp <= {cmd, idx, val};
				end
				default: begin
					resp <= 16'h0000;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// *** ecsd_command_decoder_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecsd_command_decoder_monitor
	import ecsd_pkg::*;
(
	// Inputs
	input wire logic         i_mclk,
	input wire logic         i_rst_n,
	input wire logic         i_select_n_input,
	input wire logic [111:0] i_status_set,
	// Outputs
	input wire logic         o_miso_oe_n,
	input wire logic [71:0]  o_config_bank,
	input wire logic [79:0]  o_control_bank,
	input wire logic [111:0] o_status_bank,
	input wire logic         o_self_test_enable,
	input wire logic         o_frame_exec
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_pulse;
		o_frame_exec ##1 !o_frame_exec;
	endsequence
	a_exec_pulse: assert property (o_frame_exec |-> s_pulse)
		else $error("exec strobe longer than one cycle");
	a_exec_sel: assert property (o_frame_exec |->
		i_select_n_input && $past(i_select_n_input, 2))
		else $error("exec without select high");
	a_oe_sel: assert property (o_miso_oe_n == i_select_n_input)
		else $error("data out enable wrong");
	a_cfg_rst: assert property ($rose(i_rst_n) |->
		o_config_bank == 72'h801000180110181010)
		else $error("config reset value wrong");
	a_ctrl_rst: assert property ($rose(i_rst_n) |->
		o_control_bank == 80'h1200 && o_status_bank == 112'h0)
		else $error("control or status reset value wrong");
	a_cfg_mask: assert property (
		(o_config_bank & ~72'hD7D7839BFFDF9F9F9F) == 72'h0)
		else $error("config missing bit set");
	a_ctrl_mask: assert property (
		(o_control_bank & ~80'h7F7F7F7F7F7F7F7FD7FF) == 80'h0)
		else $error("control missing bit set");
	a_cfg_hold: assert property ($changed(o_config_bank) |-> o_frame_exec)
		else $error("config changed without frame");
	a_ctrl_hold: assert property ($changed(o_control_bank) |-> o_frame_exec)
		else $error("control changed without frame");
	a_self_map: assert property (o_self_test_enable == o_control_bank[14])
		else $error("self test flag wrong");
	a_stat_set: assert property (i_status_set != 112'h0 |=>
		(o_status_bank & $past(i_status_set)) == $past(i_status_set))
		else $error("status set lost");
endmodule
bind ecsd_command_decoder ecsd_command_decoder_monitor u_mon (
	.i_mclk, .i_rst_n, .i_select_n_input, .i_status_set, .o_miso_oe_n,
	.o_config_bank, .o_control_bank, .o_status_bank,
	.o_self_test_enable, .o_frame_exec);
`default_nettype wire

// *** ecsd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecsd_host_model (
	// Serial link
	output logic     o_sclk,
	output logic     o_select_n,
	output logic     o_mosi,
	input wire logic i_miso
);
	logic [15:0] rx;
	initial begin
		o_sclk = 1'b0;
		o_select_n = 1'b1;
		o_mosi = 1'b0;
		rx = 16'h0000;
	end
	// One frame MSB first, 64 ns clock only inside the frame
	task automatic xfer(input logic [15:0] tx, input int n);
		#13 o_select_n = 1'b0;
		for (int k = 15; k > 15 - n; k--) begin
			o_mosi = tx[k];
			#16 rx = {rx[14:0], i_miso};
			o_sclk = 1'b1;
			#32 o_sclk = 1'b0;
			#16;
		end
		#16 o_select_n = 1'b1;
		o_mosi = ~o_mosi;
		#400;
	endtask
endmodule
`default_nettype wire

// *** engine_ctrl_spi_command_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module engine_ctrl_spi_command_decoder_tb_top;
	import ecsd_pkg::*;
	logic         i_mclk, i_rst_n, sclk, sel_n, mosi, miso, st_en, exec;
	logic [111:0] i_status_set, stat;
	logic [71:0]  cfg;
	logic [79:0]  ctrl;
	int           failures, tests_run;
	int           execs = 0;
	ecsd_command_decoder u_dut (.i_mclk, .i_rst_n, .i_sclk(sclk),
		.i_select_n_input(sel_n), .i_mosi(mosi), .o_miso(miso),
		.o_miso_oe_n(), .i_status_set, .o_config_bank(cfg),
		.o_control_bank(ctrl), .o_status_bank(stat),
		.o_self_test_enable(st_en), .o_frame_exec(exec));
	ecsd_host_model u_host (.o_sclk(sclk), .o_select_n(sel_n),
		.o_mosi(mosi), .i_miso(miso));
	// Counts execute strobes seen from the block
	always @(posedge i_mclk) begin
		if (exec === 1'b1) begin
			execs <= execs + 1;
		end
	end
	// ****
	// Tasks
	// ****
	task automatic check(input string s, input logic [111:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %0h got %0h", s, e, g);
		end
	endtask
	task automatic f(input logic [15:0] tx, input logic [15:0] e);
		u_host.xfer(tx, 16);
		check("reply", e, u_host.rx);
	endtask
	task automatic t_reset;
		check("cfg", 72'h801000180110181010, cfg);
		check("ctrl", 80'h1200, ctrl);
		f(16'h1400, 16'h0000);
		f(16'h1800, 16'h1401);
		f(16'h0000, 16'h1880);
		check("execs", 112'h3, execs);
		$display("reset test done");
	endtask
	task automatic t_write;
		f(16'h23FF, 16'h0000);
		f(16'h1300, 16'h23FF);
		f(16'h62FF, 16'h13DF);
		f(16'h5200, 16'h62FF);
		f(16'h0000, 16'h527F);
		check("cfg3", 112'hDF, cfg[31:24]);
		check("ctrl2", 112'h7F, ctrl[23:16]);
		$display("write test done");
	endtask
	task automatic t_echo;
		int n;
		f(16'h0ABC, 16'h0000);
		f(16'h7123, 16'h0ABC);
		f(16'h9122, 16'h0000);
		n = execs;
		u_host.xfer(16'h4000, 15);
		check("short", 112'h10, cfg[7:0]);
		check("short exec", n, execs);
		f(16'h0000, 16'h0000);
		$display("echo test done");
	endtask
	task automatic t_status;
		@(posedge i_mclk) i_status_set <= 112'h5;
		@(posedge i_mclk) i_status_set <= 112'h0;
		@(posedge i_mclk) check("set", 112'h5, stat[7:0]);
		f(16'h4004, 16'h0000);
		f(16'h3000, 16'h4004);
		f(16'h6152, 16'h3004);
		check("st_en", 112'h1, st_en);
		f(16'h40A0, 16'h6152);
		check("stat", 112'hA0, stat[7:0]);
		$display("status test done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	initial begin
		#200000;
		failures++;
		finish_test;
	end
	initial begin
		i_rst_n = 1'b0;
		i_status_set = 112'h0;
		failures = 0;
		tests_run = 0;
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_mclk);
		t_reset;
		t_write;
		t_echo;
		t_status;
		finish_test;
	end
endmodule
`default_nettype wire
